// ---- rtl/fsc_pkg.sv ----
// Shared constants and types for the flyback start-up and protection sequencer.
// Assumes a single 100 MHz system clock; all timing counts derive from it.
package fsc_pkg;
  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  // Soft-start interval, 3.5 ms, in nanoseconds.
  localparam int SOFT_START_NS = 3_500_000;
  // Soft-start interval in clock cycles, rounded up.
  localparam int SOFT_START_CYC = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least continuous brownout time, 32 ms, in nanoseconds.
  localparam int BROWNOUT_NS = 32_000_000;
  // Least brownout time in clock cycles, rounded up.
  localparam int BROWNOUT_CYC = (BROWNOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Switching period in clock cycles, about 650 kHz.
  localparam int SW_PERIOD_CYC = 154;
  // Largest duty cycle in percent.
  localparam int MAX_DUTY_PCT = 90;
  // Consecutive overvoltage switching cycles that latch.
  localparam logic [2:0] OVP_CONSEC = 3'h4;
  // Consecutive failed temperature measurements that latch.
  localparam logic [2:0] OTP_CONSEC = 3'h4;
  // Consecutive strokes ended at maximum duty that restart.
  localparam logic [3:0] MAXDUTY_CONSEC = 4'h8;
  // Width and full value of the soft-start peak limit.
  localparam int PEAK_W = 8;
  localparam logic [PEAK_W-1:0] PEAK_MAX = 8'hFF;
  localparam logic [PEAK_W-1:0] PEAK_MIN = 8'h00;
  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_WAIT    = 5'h01,
    ST_CHECK   = 5'h02,
    ST_RUN     = 5'h04,
    ST_RESTART = 5'h08,
    ST_LATCHED = 5'h10
  } fsc_state_type;
endpackage

// ---- rtl/fsc_pwm_if.sv ----
// Interface between the sequencer and its gate pulse generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface fsc_pwm_if;
  logic en;          // Switching allowed this cycle.
  logic cs_trip;     // Current sense reached the peak limit.
  logic gate;        // Gate drive level.
  logic stroke_end;  // One-cycle pulse at the end of each switching period.
  logic stroke_max;  // The stroke just ended was cut at maximum duty.
  modport main (output en, output cs_trip, input gate, input stroke_end, input stroke_max);
  modport pwm  (input en, input cs_trip, output gate, output stroke_end, output stroke_max);
endinterface

// ---- rtl/fsc_pwm.sv ----
// Fixed-period gate pulse generator with a hard duty-cycle ceiling.
// Assumes the current sense trip input is synchronous to the system clock.
`timescale 1ns/10ps
module fsc_pwm #(
  parameter int PERIOD_CYC = fsc_pkg::SW_PERIOD_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  fsc_pwm_if.pwm    bus
);
  // Longest on-time in cycles, rounded down so duty never exceeds the ceiling.
  localparam int MAX_ON = PERIOD_CYC * fsc_pkg::MAX_DUTY_PCT / 100;
  localparam int PW     = $clog2(PERIOD_CYC);
  localparam logic [PW-1:0] CNT_LAST = PW'(PERIOD_CYC - 1);
  localparam logic [PW-1:0] ON_LAST  = PW'(MAX_ON - 1);
  localparam logic [PW-1:0] CNT_ZERO = '0;

  // Refuse periods too short to hold a useful on-time.
  if (PERIOD_CYC < 4) begin : g_chk
    $error("fsc_pwm: PERIOD_CYC too small.");
  end

  // Whole state of the generator.
  typedef struct packed {
    logic [PW-1:0] cnt;         // Position within the switching period.
    logic          gate;        // Gate level.
    logic          cut;         // Current stroke was cut at maximum duty.
    logic          stroke_end;  // End-of-period pulse.
    logic          stroke_max;  // Cut flag of the finished stroke.
  } fsc_pwm_state_type;

  fsc_pwm_state_type s_r;
  fsc_pwm_state_type s_nxt;

  // Next-state logic for period count and gate.
  always_comb begin
    s_nxt            = s_r;
    s_nxt.stroke_end = 1'b0;
    if (s_r.cnt == CNT_LAST) begin
      // Period ends: report the stroke and start a new one.
      s_nxt.cnt        = CNT_ZERO;
      s_nxt.stroke_end = 1'b1;
      s_nxt.stroke_max = s_r.cut;
      s_nxt.cut        = 1'b0;
      s_nxt.gate       = bus.en;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_r.gate && s_r.cnt == ON_LAST) begin
        s_nxt.gate = 1'b0;
        s_nxt.cut  = 1'b1;
      end else if (bus.cs_trip) begin
        // Peak current reached: end the primary stroke.
        s_nxt.gate = 1'b0;
      end
    end
    // Switching withdrawn: gate drops at once.
    if (!bus.en) begin
      s_nxt.gate = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.gate       = s_r.gate;
  assign bus.stroke_end = s_r.stroke_end;
  assign bus.stroke_max = s_r.stroke_max;

  // Gate never stays high past the longest on-time.
  AST_DUTY_CEILING: assert property (
    @(posedge sys_clk_i) disable iff (rst_i) s_r.gate |-> s_r.cnt <= ON_LAST)
    else $error("Gate high beyond maximum duty.");
endmodule

// ---- rtl/fsc_seq.sv ----
// Start-up and protection sequencer of a flyback controller.
// Assumes all comparator indications are qualified levels or pulses on sys_clk_i.
// Summary of operation
// - Wait at start-up level, check sense first.
// - Start only with mains and temperature good.
// - Ramp peak limit over 3.5 ms soft-start.
// - Any protection stops gate, restart or latch.
// - Brownout and maximum duty lead to restart.
// - Overload, lockout, overvoltage, overtemperature latch off.
// - Restart: wait lockout, power down, recharge.
// - Latch: power down now, clamp supply.
// - Lockout during run is a latched protection.
// - Duty cycle never above 90 percent.
// - Brownout after 32 ms continuously below.
// - External overtemperature after four failed measurements.
// - Restart after eight strokes at maximum duty.
// - Supply overvoltage latches after four cycles.
`timescale 1ns/10ps
module fsc_seq #(
  parameter int SOFT_START_CYC = fsc_pkg::SOFT_START_CYC,
  parameter int BROWNOUT_CYC   = fsc_pkg::BROWNOUT_CYC,
  parameter int PERIOD_CYC     = fsc_pkg::SW_PERIOD_CYC
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      supply_startup_i,
  input  wire logic                      supply_low_lockout_i,
  input  wire logic                      supply_latch_release_i,
  input  wire logic                      meas_mains_done_i,
  input  wire logic                      mains_above_brownin_i,
  input  wire logic                      mains_below_brownout_i,
  input  wire logic                      meas_temp_done_i,
  input  wire logic                      temp_above_det_i,
  input  wire logic                      current_sense_pin_trip_i,
  input  wire logic                      ovp_supply_i,
  input  wire logic                      ovp_sense_i,
  input  wire logic                      int_ovp_i,
  input  wire logic                      int_otp_i,
  input  wire logic                      overload_timeout_protection_i,
  output logic                           gate_o,
  output logic                           power_down_o,
  output logic                           supply_clamp_o,
  output logic [fsc_pkg::PEAK_W-1:0]     peak_limit_o,
  output logic                           restart_o,
  output logic                           latched_o
);
  // Number of peak limit steps from the lowest to the full level.
  localparam int PEAK_STEPS = int'(fsc_pkg::PEAK_MAX);
  // Soft-start cycles per peak limit step.
  localparam int SS_STEP = SOFT_START_CYC / PEAK_STEPS;
  localparam int SS_W    = $clog2(SS_STEP + 1);
  localparam int BO_W    = $clog2(BROWNOUT_CYC + 1);
  localparam logic [SS_W-1:0] SS_LAST = SS_W'(SS_STEP - 1);
  localparam logic [BO_W-1:0] BO_LAST = BO_W'(BROWNOUT_CYC - 1);
  // Last counts of the run-length counters, one below the firing count.
  localparam logic [3:0] MAXDUTY_M1 = fsc_pkg::MAXDUTY_CONSEC - 4'h1;
  localparam logic [2:0] OVP_M1     = fsc_pkg::OVP_CONSEC - 3'h1;
  localparam logic [2:0] OTP_M1     = fsc_pkg::OTP_CONSEC - 3'h1;

  // Refuse counts the counters cannot serve.
  if (SOFT_START_CYC < PEAK_STEPS || BROWNOUT_CYC < 2) begin : g_chk
    $error("fsc_seq: timing parameters too small.");
  end

  // Whole state of the sequencer.
  typedef struct packed {
    fsc_pkg::fsc_state_type       st;        // Sequencer state.
    logic                         mains_ok;  // Mains passed the brownin check.
    logic                         temp_ok;   // Temperature passed its check.
    logic [2:0]                   ovp_cnt;   // Supply overvoltage run length.
    logic [2:0]                   sns_cnt;   // Sense-pin overvoltage run length.
    logic [2:0]                   otp_cnt;   // Failed temperature run length.
    logic [3:0]                   md_cnt;    // Maximum duty stroke run length.
    logic [BO_W-1:0]              bo_cnt;    // Cycles continuously below brownout.
    logic [SS_W-1:0]              ss_cnt;    // Cycles within a soft-start step.
    logic [fsc_pkg::PEAK_W-1:0]   peak;      // Allowed peak level.
  } fsc_seq_state_type;

  fsc_seq_state_type s_r;
  fsc_seq_state_type s_nxt;
  fsc_pwm_if         pif ();
  logic              latch_evt;    // A latched protection fires this cycle.
  logic              restart_evt;  // A restart protection fires this cycle.
  logic              bo_hit;       // Brownout time elapsed.
  logic              md_hit;       // Eighth maximum duty stroke.
  logic              ovp_hit;      // Fourth supply overvoltage cycle.
  logic              sns_hit;      // Fourth sense overvoltage cycle.
  logic              otp_hit;      // Fourth failed temperature measurement.
  logic              in_run;       // Sequencer is switching.

  assign in_run = (s_r.st == fsc_pkg::ST_RUN);

  // Protection event decode from the run-length counters and direct inputs.
  always_comb begin
    bo_hit  = mains_below_brownout_i && s_r.bo_cnt == BO_LAST;
    md_hit  = pif.stroke_end && pif.stroke_max && s_r.md_cnt == MAXDUTY_M1;
    ovp_hit = pif.stroke_end && ovp_supply_i && s_r.ovp_cnt == OVP_M1;
    sns_hit = pif.stroke_end && ovp_sense_i && s_r.sns_cnt == OVP_M1;
    otp_hit = meas_temp_done_i && !temp_above_det_i && s_r.otp_cnt == OTP_M1;
    latch_evt = in_run && (overload_timeout_protection_i || supply_low_lockout_i ||
                int_ovp_i || int_otp_i || ovp_hit || sns_hit || otp_hit);
    restart_evt = in_run && (bo_hit || md_hit);
  end

  // Next-state logic of the sequencer.
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      fsc_pkg::ST_WAIT: begin
        if (supply_startup_i) begin
          s_nxt.st       = fsc_pkg::ST_CHECK;
          s_nxt.mains_ok = 1'b0;
          s_nxt.temp_ok  = 1'b0;
        end
      end
      fsc_pkg::ST_CHECK: begin
        // Record the latest result of each measuring phase.
        if (meas_mains_done_i) begin
          s_nxt.mains_ok = mains_above_brownin_i;
        end
        if (meas_temp_done_i) begin
          s_nxt.temp_ok = temp_above_det_i;
        end
        if (s_r.mains_ok && s_r.temp_ok) begin
          s_nxt         = '0;
          s_nxt.st      = fsc_pkg::ST_RUN;
        end else if (supply_low_lockout_i) begin
          // Supply collapsed before switching: wait for recharge.
          s_nxt.st = fsc_pkg::ST_WAIT;
        end
      end
      fsc_pkg::ST_RUN: begin
        if (s_r.peak != fsc_pkg::PEAK_MAX) begin
          if (s_r.ss_cnt == SS_LAST) begin
            s_nxt.ss_cnt = '0;
            s_nxt.peak   = s_r.peak + 1'b1;
          end else begin
            s_nxt.ss_cnt = s_r.ss_cnt + 1'b1;
          end
        end
        s_nxt.bo_cnt = mains_below_brownout_i ? s_r.bo_cnt + 1'b1 : '0;
        // Per-cycle run lengths, cleared by any good cycle.
        if (pif.stroke_end) begin
          s_nxt.md_cnt  = pif.stroke_max ? s_r.md_cnt + 1'b1 : 4'h0;
          s_nxt.ovp_cnt = ovp_supply_i ? s_r.ovp_cnt + 1'b1 : 3'h0;
          s_nxt.sns_cnt = ovp_sense_i ? s_r.sns_cnt + 1'b1 : 3'h0;
        end
        if (meas_temp_done_i) begin
          s_nxt.otp_cnt = temp_above_det_i ? 3'h0 : s_r.otp_cnt + 1'b1;
        end
        if (latch_evt) begin
          s_nxt.st   = fsc_pkg::ST_LATCHED;
          s_nxt.peak = fsc_pkg::PEAK_MIN;
        end else if (restart_evt) begin
          s_nxt.st   = fsc_pkg::ST_RESTART;
          s_nxt.peak = fsc_pkg::PEAK_MIN;
        end
      end
      fsc_pkg::ST_RESTART: begin
        if (supply_low_lockout_i) begin
          s_nxt.st = fsc_pkg::ST_WAIT;
        end
      end
      fsc_pkg::ST_LATCHED: begin
        s_nxt.st = fsc_pkg::ST_LATCHED;
      end
      default: begin
        s_nxt = '0;
        s_nxt.st = fsc_pkg::ST_WAIT;
      end
    endcase
    if (supply_latch_release_i) begin
      s_nxt    = '0;
      s_nxt.st = fsc_pkg::ST_WAIT;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_r    <= '0;
      s_r.st <= fsc_pkg::ST_WAIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Gate generator; it sees the next state so the gate drops on the trip edge.
  assign pif.en      = (s_nxt.st == fsc_pkg::ST_RUN);
  assign pif.cs_trip = current_sense_pin_trip_i;

  fsc_pwm #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_pwm (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (pif.pwm)
  );

  // Outputs decoded from registered state.
  assign gate_o         = pif.gate;
  assign power_down_o   = (s_r.st == fsc_pkg::ST_WAIT) || (s_r.st == fsc_pkg::ST_LATCHED);
  assign supply_clamp_o = (s_r.st == fsc_pkg::ST_LATCHED);
  assign peak_limit_o   = s_r.peak;
  assign restart_o      = (s_r.st == fsc_pkg::ST_RESTART);
  assign latched_o      = (s_r.st == fsc_pkg::ST_LATCHED);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // No gate outside the running state.
  AST_NO_GATE_IDLE: assert property (
    !in_run |-> !gate_o) else $error("Gate driven while not running.");
  // Running is entered only after both checks passed.
  AST_START_CHECKED: assert property (
    $rose(in_run) |-> $past(s_r.mains_ok && s_r.temp_ok && s_r.st == fsc_pkg::ST_CHECK))
    else $error("Switching started without passed checks.");
  // Soft-start begins at the lowest peak and is at most one step up a cycle later.
  AST_SOFT_START: assert property (
    $rose(in_run) |-> peak_limit_o == fsc_pkg::PEAK_MIN ##1 (!in_run ||
    peak_limit_o <= fsc_pkg::PEAK_MIN + 8'h01)) else $error("Soft-start not ramping.");
  // A latching event ends switching and clamps next cycle.
  AST_LATCH_PATH: assert property (
    latch_evt && !supply_latch_release_i |=> !gate_o && supply_clamp_o && power_down_o)
    else $error("Latched protection did not clamp.");
  // A restart event enters restart next cycle with gate off and no clamp.
  AST_RESTART_PATH: assert property (
    restart_evt && !latch_evt && !supply_latch_release_i |=> restart_o && !gate_o
    && !supply_clamp_o) else $error("Restart path not taken.");
  // Restart ends in power-down once lockout is seen.
  AST_RESTART_WAIT: assert property (
    restart_o && supply_low_lockout_i && !supply_latch_release_i |=> power_down_o
    && !latched_o) else $error("Restart did not power down.");
  // Lockout while running latches.
  AST_LOCKOUT_LATCH: assert property (
    in_run && supply_low_lockout_i && !supply_latch_release_i |=> latched_o)
    else $error("Lockout during run did not latch.");
  // Fourth consecutive supply overvoltage latches.
  AST_OVP_FOUR: assert property (
    in_run && pif.stroke_end && ovp_supply_i && s_r.ovp_cnt == 3'h3
    && !supply_latch_release_i |=> latched_o) else $error("Overvoltage count missed.");
  // Latch holds until release.
  AST_LATCH_HOLD: assert property (
    latched_o && !supply_latch_release_i |=> latched_o) else $error("Latch left early.");

  COV_RUN:     cover property ($rose(in_run));
  COV_RESTART: cover property ($rose(restart_o));
  COV_LATCH:   cover property ($rose(latched_o));
  COV_SS_DONE: cover property (in_run && peak_limit_o == fsc_pkg::PEAK_MAX);
endmodule

// ---- verification/fsc_front_model.sv ----
// Behavioural model of the comparators and current sense facing the sequencer.
// Assumes the system clock only; measured levels are chosen by the testbench.
`timescale 1ns/10ps
module fsc_front_model (
  input  wire logic       sys_clk_i,
  input  wire logic       gate_i,
  input  wire logic       mains_good_i,
  input  wire logic       temp_good_i,
  input  wire logic [7:0] trip_after_i,
  output logic            mains_done_o,
  output logic            mains_above_o,
  output logic            temp_done_o,
  output logic            temp_above_o,
  output logic            trip_o
);
  logic [3:0] phase_r = 4'h0;  // Measuring clock, mains half then temperature half.
  logic [7:0] on_r    = 8'h00;  // Cycles the gate has been high in this stroke.

  // The measuring clock free-runs; the on-time count restarts with each stroke.
  always @(posedge sys_clk_i) begin
    phase_r <= phase_r + 4'h1;
    on_r    <= gate_i ? on_r + 8'h01 : 8'h00;
  end

  // Each phase reports one result at its end.
  assign mains_done_o = (phase_r == 4'h0);
  assign temp_done_o  = (phase_r == 4'h8);
  // Outside the reporting cycle a result line toggles, so stale reads show up.
  assign mains_above_o = mains_done_o ? mains_good_i : phase_r[0];
  assign temp_above_o  = temp_done_o ? temp_good_i : phase_r[0];
  // The current reaches the peak a fixed time into the stroke; zero never trips.
  assign trip_o = gate_i && (trip_after_i != 8'h00) && (on_r >= trip_after_i);
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench of the start-up and protection sequencer.
// Assumes the front model supplies measurement results and current trips.
`timescale 1ns/10ps
module tb;
  localparam int SS_CYC  = 510;  // Shortened soft-start.
  localparam int BO_CYC  = 50;   // Shortened brownout time.
  localparam int PER_CYC = 20;   // Shortened switching period.
  localparam int MAX_ON  = PER_CYC * fsc_pkg::MAX_DUTY_PCT / 100;
  logic       sys_clk_i;
  logic       rst_i;
  logic       startup;     // Supply at start-up level.
  logic       latch_rel;   // Supply below latch release.
  logic [6:0] fault;       // Int OVP, int OTP, overload, lockout, brownout, OVP supply, OVP sense.
  logic       mains_good;  // Mains measurement result.
  logic       temp_good;   // Temperature measurement result.
  logic [7:0] trip_after;  // Stroke on-time before the current trips.
  logic       m_done, m_above, t_done, t_above, trip;
  logic       gate_o, power_down_o, supply_clamp_o, restart_o, latched_o;
  logic [7:0] peak_limit_o;
  int         failures = 0;
  int         check_count = 0;

  fsc_seq #(.SOFT_START_CYC(SS_CYC), .BROWNOUT_CYC(BO_CYC), .PERIOD_CYC(PER_CYC)) fsc_seq_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .supply_startup_i(startup),
    .supply_low_lockout_i(fault[3]), .supply_latch_release_i(latch_rel),
    .meas_mains_done_i(m_done), .mains_above_brownin_i(m_above),
    .mains_below_brownout_i(fault[4]), .meas_temp_done_i(t_done), .temp_above_det_i(t_above),
    .current_sense_pin_trip_i(trip), .ovp_supply_i(fault[5]), .ovp_sense_i(fault[6]),
    .int_ovp_i(fault[0]), .int_otp_i(fault[1]), .overload_timeout_protection_i(fault[2]),
    .gate_o(gate_o), .power_down_o(power_down_o), .supply_clamp_o(supply_clamp_o),
    .peak_limit_o(peak_limit_o), .restart_o(restart_o), .latched_o(latched_o));

  fsc_front_model fsc_front_model_inst (
    .sys_clk_i(sys_clk_i), .gate_i(gate_o), .mains_good_i(mains_good), .temp_good_i(temp_good),
    .trip_after_i(trip_after), .mains_done_o(m_done), .mains_above_o(m_above),
    .temp_done_o(t_done), .temp_above_o(t_above), .trip_o(trip));

  // The 100 MHz clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compares one result, widened to a byte.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Widens a flag to a byte.
  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction

  // Lets n edges pass and samples just after the last one.
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Waits a bounded time for gate, power-down, restart or latched output to be high.
  task automatic wait_hi(input int k, input int lim);
    logic [3:0] v;
    v = {latched_o, restart_o, power_down_o, gate_o};
    for (int n = 0; v[k] !== 1'b1; n++) begin
      if (n > lim) begin
        failures++;
        $display("[FAIL] wait on output %0d expected 1 seen %b", k, v[k]);
        tally_and_finish();
      end
      step(1);
      v = {latched_o, restart_o, power_down_o, gate_o};
    end
  endtask

  // Resets the sequencer with the supply at start-up level.
  task automatic do_reset(input logic [7:0] trp, input logic mg, input logic tg);
    @(posedge sys_clk_i);
    rst_i      <= 1'b1;
    fault      <= 7'h00;
    mains_good <= mg;
    temp_good  <= tg;
    trip_after <= trp;
    startup    <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    step(1);
  endtask

  // Starts switching and returns at the first gate pulse.
  task automatic start_run(input logic [7:0] trp);
    do_reset(trp, 1'b1, 1'b1);
    wait_hi(0, 200);
  endtask

  // Restart tail: discharge to lockout, power down, recharge, switch again.
  task automatic restart_tail();
    chk("gate in restart", 8'h00, b(gate_o));
    chk("power down in restart", 8'h00, b(power_down_o));
    @(posedge sys_clk_i);
    fault[3] <= 1'b1;
    startup  <= 1'b0;
    step(2);
    chk("power down after lockout", 8'h01, b(power_down_o));
    @(posedge sys_clk_i);
    fault[3] <= 1'b0;
    startup  <= 1'b1;
    wait_hi(0, 200);
    chk("gate after recharge", 8'h01, b(gate_o));
  endtask

  // No switching unless both measurements pass; lockout in check waits again.
  task automatic t_start();
    int highs;
    // Cases: mains bad, temperature bad, both bad.
    for (int c = 0; c < 3; c++) begin
      do_reset(8'h05, c == 1, c == 0);
      highs = 0;
      for (int i = 0; i < 80; i++) begin
        highs += gate_o;
        step(1);
      end
      chk("gate before checks pass", 8'h00, highs[7:0]);
    end
    // Supply collapses while still checking: back to waiting, not latched.
    @(posedge sys_clk_i);
    fault[3] <= 1'b1;
    startup  <= 1'b0;
    step(2);
    chk("waiting after lockout in check", 8'h01, b(power_down_o));
    chk("lockout in check not latched", 8'h00, b(latched_o));
    @(posedge sys_clk_i);
    fault[3]   <= 1'b0;
    startup    <= 1'b1;
    mains_good <= 1'b1;
    temp_good  <= 1'b1;
    wait_hi(0, 200);
    chk("gate after checks pass", 8'h01, b(gate_o));
  endtask

  // Peak limit ramps up over the soft-start.
  task automatic t_soft();
    start_run(8'h05);
    chk("peak below full at start", 8'h01, b(peak_limit_o < 8'h40));
    step(SS_CYC / 2);
    chk("peak below full midway", 8'h01, b(peak_limit_o < 8'hFF));
    step(SS_CYC / 2 + 20);
    chk("peak full after ramp", 8'hFF, peak_limit_o);
  endtask

  // Internal overvoltage, internal overtemperature, overload and lockout in run all latch.
  task automatic t_latch();
    for (int k = 0; k < 4; k++) begin
      start_run(8'h05);
      @(posedge sys_clk_i);
      fault[k] <= 1'b1;
      step(1);
      chk("gate on protection", 8'h00, b(gate_o));
      chk("latched", 8'h01, b(latched_o));
      chk("clamp", 8'h01, b(supply_clamp_o));
      chk("power down at latch", 8'h01, b(power_down_o));
      @(posedge sys_clk_i);
      fault[k] <= 1'b0;
      step(30);
      chk("latch held", 8'h01, b(latched_o));
      // The supply is below start-up level while it falls to release.
      @(posedge sys_clk_i);
      latch_rel <= 1'b1;
      startup   <= 1'b0;
      @(posedge sys_clk_i);
      latch_rel <= 1'b0;
      step(1);
      chk("latch released", 8'h00, b(latched_o));
      chk("waiting after release", 8'h01, b(power_down_o));
    end
  endtask

  // Strokes cut at maximum duty, then restart after eight.
  task automatic t_maxduty();
    int run_len;
    int max_len;
    start_run(8'h00);
    run_len = 0;
    max_len = 0;
    for (int i = 0; i < 100; i++) begin
      run_len = gate_o ? run_len + 1 : 0;
      if (run_len > max_len) max_len = run_len;
      step(1);
    end
    chk("longest on-time", MAX_ON[7:0], max_len[7:0]);
    chk("no restart before eighth", 8'h00, b(restart_o));
    wait_hi(2, 120);
    chk("max duty not latched", 8'h00, b(latched_o));
    restart_tail();
  endtask

  // A short dip is ignored; a full brownout restarts.
  task automatic t_brownout();
    start_run(8'h05);
    @(posedge sys_clk_i);
    fault[4] <= 1'b1;
    step(BO_CYC - 5);
    @(posedge sys_clk_i);
    fault[4] <= 1'b0;
    step(2);
    chk("short dip no restart", 8'h00, b(restart_o));
    @(posedge sys_clk_i);
    fault[4] <= 1'b1;
    step(BO_CYC - 2);
    chk("brownout not early", 8'h00, b(restart_o));
    wait_hi(2, 4);
    chk("brownout not latched", 8'h00, b(latched_o));
    @(posedge sys_clk_i);
    fault[4] <= 1'b0;
    step(1);
    restart_tail();
  endtask

  // Overvoltage counts are cleared by a good stroke and latch at four.
  task automatic t_ovp();
    for (int k = 5; k < 7; k++) begin
      start_run(8'h05);
      @(posedge sys_clk_i);
      fault[k] <= 1'b1;
      step(50);
      @(posedge sys_clk_i);
      fault[k] <= 1'b0;
      step(30);
      @(posedge sys_clk_i);
      fault[k] <= 1'b1;
      step(50);
      chk("overvoltage below four", 8'h00, b(latched_o));
      wait_hi(3, 100);
      chk("overvoltage gate off", 8'h00, b(gate_o));
    end
  endtask

  // Four failed temperature results latch.
  task automatic t_temp();
    start_run(8'h05);
    @(posedge sys_clk_i);
    temp_good <= 1'b0;
    step(40);
    chk("temperature below four", 8'h00, b(latched_o));
    wait_hi(3, 100);
    chk("temperature clamp", 8'h01, b(supply_clamp_o));
  endtask

  // Main sequence.
  initial begin
    rst_i      = 1'b1;
    fault      = 7'h00;
    startup    = 1'b0;
    latch_rel  = 1'b0;
    mains_good = 1'b0;
    temp_good  = 1'b0;
    trip_after = 8'h00;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_start();
    t_soft();
    t_latch();
    t_maxduty();
    t_brownout();
    t_ovp();
    t_temp();
    tally_and_finish();
  end
endmodule
